/* shared/tsid_defines.vh */
// Constants for the task switch and interrupt dispatch block
`ifndef TSID_DEFINES_VH
`define TSID_DEFINES_VH

// ----------------------------------------------------------------------
// Task state record layout, as word indices (byte offset = index * 4)
// ----------------------------------------------------------------------
`define TSID_IDX_PTR0        5'h01
`define TSID_IDX_SAVE_FIRST  5'h08
`define TSID_IDX_SAVE_LAST   5'h17
`define TSID_IDX_LOAD_FIRST  5'h07
`define TSID_IDX_LOAD_LAST   5'h18
`define TSID_IDX_PAGE_BASE   5'h07
`define TSID_IDX_IP          5'h08
`define TSID_IDX_FLAGS       5'h09
`define TSID_IDX_GPR0        5'h0A
`define TSID_IDX_SEG0        5'h12
`define TSID_IDX_LOCAL_SEL   5'h18

// ----------------------------------------------------------------------
// 64-bit task state record byte offsets
// ----------------------------------------------------------------------
`define TSID_OFF_RSP0        8'h04
`define TSID_OFF_IST1        8'h24
`define TSID_OFF_IOMAP       8'h64

// ----------------------------------------------------------------------
// Descriptor sizes in words and gate types
// ----------------------------------------------------------------------
`define TSID_WORDS_LEGACY    3'h2
`define TSID_WORDS_LONG      3'h4
`define TSID_TYPE_TASK       4'h5
`define TSID_TYPE_INT16      4'h6
`define TSID_TYPE_TRAP16     4'h7
`define TSID_TYPE_INT32      4'hE
`define TSID_TYPE_TRAP32     4'hF

// ----------------------------------------------------------------------
// Software vector kinds and their fixed vectors
// ----------------------------------------------------------------------
`define TSID_SW_INTN         2'h0
`define TSID_SW_INTO         2'h1
`define TSID_SW_INT3         2'h2
`define TSID_SW_BOUND        2'h3
`define TSID_VEC_BP          8'h03
`define TSID_VEC_OVF         8'h04
`define TSID_VEC_BR          8'h05

// ----------------------------------------------------------------------
// Fault codes and reset values
// ----------------------------------------------------------------------
`define TSID_FLT_NONE        3'h0
`define TSID_FLT_BAD_TYPE    3'h1
`define TSID_FLT_TASK_GATE   3'h2
`define TSID_FLT_HW_SWITCH   3'h3
`define TSID_FLT_LIMIT       3'h4
`define TSID_TPL_RESET       4'h0
`define TSID_IDT_LIMIT_RESET 16'hFFFF

`endif

/* hdl/tsid_mem_port.v */
// Single outstanding memory request port for records and tables
`timescale 1ns/1ns

module tsid_mem_port
(
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Command side
    input  wire        cmd_valid,
    input  wire        cmd_we,
    input  wire [63:0] cmd_addr,
    input  wire [31:0] cmd_wdata,
    output wire        cmd_ready,
    output reg         rsp_valid,
    output reg  [31:0] rsp_data,
    // System memory side
    output reg         mem_req,
    output reg         mem_we,
    output reg  [63:0] mem_addr,
    output reg  [31:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata
);

// ----------------------------------------------------------------------
// One access at a time; request holds until the response arrives
// ----------------------------------------------------------------------
assign cmd_ready = ~mem_req;

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        mem_req   <= 1'b0;
        mem_we    <= 1'b0;
        mem_addr  <= 64'h0;
        mem_wdata <= 32'h0;
        rsp_valid <= 1'b0;
        rsp_data  <= 32'h0;
    end
    else
    begin
        rsp_valid <= 1'b0;
        if (!mem_req && cmd_valid)
        begin
            mem_req   <= 1'b1;
            mem_we    <= cmd_we;
            mem_addr  <= cmd_addr;
            mem_wdata <= cmd_wdata;
        end
        else if (mem_req && mem_ack)
        begin
            mem_req   <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_data  <= mem_rdata;
        end
    end
end

endmodule

/* hdl/tsid_dispatch.v */
// Task switch and interrupt dispatch engine
`timescale 1ns/1ns
`include "tsid_defines.vh"

// Operation
// - Switch saves current state to old record, then loads new selector.
// - New record is located through its global table descriptor first.
// - Load registers, page base, flags, pointer from new record; then start.
// - Task register always holds the current record selector.
// - Record holds registers, flags, pointer, three stacks, local and page.
// - Call or jump naming a record selector starts a task switch.
// - Task gate names a record; entering it performs a task switch.
// - Vectors come from hardware, external controller, or four instructions.
// - Vector indexes the handler table at the base register's address.
// - Only interrupt, trap or task gates are accepted as entries.
// - Interrupt or trap gate enters like a call gate; task gate switches.
// - Long mode has no hardware switch; record base comes from descriptor.
// - Long mode reads 16-byte handler entries with 64-bit offsets.
// - Task gates in the handler table are refused in long mode.
// - Handler table base register holds a 64-bit base.
// - Task register holds a 64-bit record base in long mode.
// - 64-bit record gives level stacks, stack table, and map offset.
// - Long mode priority control register reads and writes priority level.
// - Legacy privilege change takes the new stack from the current record.
// - Long mode privilege change sets the stack selector to null.

module tsid_dispatch
(
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Mode and context of the running code
    input  wire        long_mode,
    input  wire [1:0]  cpl,
    input  wire [63:0] gdt_base,
    // Vector sources
    input  wire        hw_vec_valid,
    input  wire [7:0]  hw_vec,
    output wire        hw_vec_ready,
    input  wire        ext_vec_valid,
    input  wire [7:0]  ext_vec,
    output wire        ext_vec_ready,
    input  wire        sw_vec_valid,
    input  wire [1:0]  sw_kind,
    input  wire [7:0]  sw_vec,
    output wire        sw_vec_ready,
    // Task switch and task register load requests
    input  wire        switch_valid,
    input  wire [15:0] switch_sel,
    output wire        switch_ready,
    input  wire        tr_load_valid,
    input  wire [15:0] tr_load_sel,
    output wire        tr_load_ready,
    // Handler table base register and priority control register
    input  wire        idt_wr,
    input  wire [63:0] idt_wbase,
    input  wire [15:0] idt_wlimit,
    input  wire        prio_wr,
    input  wire [3:0]  prio_wdata,
    output wire [3:0]  prio_rdata,
    // Execution state exchange
    output reg  [4:0]  ctx_idx_r,
    input  wire [31:0] ctx_save_data,
    output reg         ctx_load_we_r,
    output reg  [4:0]  ctx_load_idx_r,
    output reg  [31:0] ctx_load_data_r,
    output reg         task_begin_r,
    // Handler entry results
    output reg         handler_valid_r,
    output reg  [15:0] handler_sel_r,
    output reg  [63:0] handler_off_r,
    output reg         handler_trap_r,
    output reg         stack_valid_r,
    output reg  [15:0] stack_sel_r,
    output reg  [63:0] stack_ptr_r,
    output reg         fault_r,
    output reg  [2:0]  fault_code_r,
    // Task register and status
    output reg  [15:0] tr_sel_r,
    output reg  [63:0] tr_base_r,
    output reg  [19:0] tr_limit_r,
    output wire [63:0] iomap_word_addr,
    output wire        busy,
    // System memory
    output wire        mem_req,
    output wire        mem_we,
    output wire [63:0] mem_addr,
    output wire [31:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata
);

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
localparam ST_IDLE  = 3'h0;
localparam ST_VEC   = 3'h1;
localparam ST_GATE  = 3'h2;
localparam ST_STK   = 3'h3;
localparam ST_SAVE  = 3'h4;
localparam ST_GDESC = 3'h5;
localparam ST_TRSET = 3'h6;
localparam ST_LOAD  = 3'h7;

reg  [2:0]  state_r;
reg  [2:0]  cnt_r;
reg         pend_r;
reg         ld_only_r;
reg  [7:0]  vec_r;
reg  [15:0] new_sel_r;
reg  [7:0]  stk_off_r;
reg  [63:0] idt_base_r;
reg  [15:0] idt_limit_r;
reg  [3:0]  tpl_r;
reg         cmd_valid_r;
reg  [31:0] desc_r [0:3];

reg  [63:0] acc_addr;
wire        cmd_ready;
wire        rsp_valid;
wire [31:0] rsp_data;

// ----------------------------------------------------------------------
// Request arbitration: hardware, then controller, then software
// ----------------------------------------------------------------------
wire idle     = (state_r == ST_IDLE);
wire ext_ok   = (ext_vec[7:4] > tpl_r);
wire take_hw  = idle & hw_vec_valid;
wire take_ext = idle & ~hw_vec_valid & ext_vec_valid & ext_ok;
wire any_ext  = ext_vec_valid & ext_ok;
wire take_sw  = idle & ~hw_vec_valid & ~any_ext & sw_vec_valid;
wire any_vec  = hw_vec_valid | any_ext | sw_vec_valid;
wire take_tsw = idle & ~any_vec & switch_valid;
wire take_trl = idle & ~any_vec & ~switch_valid & tr_load_valid;

assign hw_vec_ready  = idle;
assign ext_vec_ready = idle & ~hw_vec_valid & ext_ok;
assign sw_vec_ready  = idle & ~hw_vec_valid & ~any_ext;
assign switch_ready  = idle & ~any_vec;
assign tr_load_ready = idle & ~any_vec & ~switch_valid;
assign busy          = ~idle;
assign prio_rdata    = tpl_r;
assign iomap_word_addr = tr_base_r + {56'h0, `TSID_OFF_IOMAP};

// INTO, INT3 and BOUND map to their fixed vectors; INTN uses sw_vec
reg [7:0] sw_vec_sel;
always @*
begin
    case (sw_kind)
        `TSID_SW_INTO:  sw_vec_sel = `TSID_VEC_OVF;
        `TSID_SW_INT3:  sw_vec_sel = `TSID_VEC_BP;
        `TSID_SW_BOUND: sw_vec_sel = `TSID_VEC_BR;
        default:        sw_vec_sel = sw_vec;
    endcase
end

// ----------------------------------------------------------------------
// Access address and descriptor decode
// ----------------------------------------------------------------------
wire [2:0]  nwords   = long_mode ? `TSID_WORDS_LONG : `TSID_WORDS_LEGACY;
wire        last_wd  = (cnt_r == nwords - 3'h1);
wire [63:0] cnt_off  = {59'h0, cnt_r, 2'b00};
wire [63:0] ent_off  = long_mode ? {52'h0, vec_r, 4'h0}
                                 : {53'h0, vec_r, 3'h0};
wire [15:0] ent_last = long_mode ? {4'h0, vec_r, 4'hF}
                                 : {5'h0, vec_r, 3'h7};
wire [3:0]  gate_typ = desc_r[1][11:8];
wire [2:0]  gate_ist = desc_r[1][2:0];
wire [1:0]  tgt_lvl  = desc_r[0][17:16];
wire [2:0]  ist_m1   = gate_ist - 3'h1;
wire        is_int   = (gate_typ == `TSID_TYPE_INT32) |
                       (gate_typ == `TSID_TYPE_TRAP32) |
                       (~long_mode & ((gate_typ == `TSID_TYPE_INT16) |
                                      (gate_typ == `TSID_TYPE_TRAP16)));

// Address of the word that the current state reaches
always @*
begin
    case (state_r)
        ST_VEC:   acc_addr = idt_base_r + ent_off + cnt_off;
        ST_STK:   acc_addr = tr_base_r + {56'h0, stk_off_r} + cnt_off;
        ST_GDESC: acc_addr = gdt_base + {48'h0, new_sel_r[15:3], 3'h0}
                             + cnt_off;
        default:  acc_addr = tr_base_r + {57'h0, ctx_idx_r, 2'b00};
    endcase
end

// Gathered descriptor words, kept without reset as plain data
always @(posedge clk)
begin
    if (rsp_valid && (state_r == ST_VEC || state_r == ST_GDESC))
        desc_r[cnt_r[1:0]] <= rsp_data;
end

// ----------------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------------
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        state_r         <= ST_IDLE;
        cnt_r           <= 3'h0;
        pend_r          <= 1'b0;
        ld_only_r       <= 1'b0;
        vec_r           <= 8'h0;
        new_sel_r       <= 16'h0;
        stk_off_r       <= 8'h0;
        idt_base_r      <= 64'h0;
        idt_limit_r     <= `TSID_IDT_LIMIT_RESET;
        tpl_r           <= `TSID_TPL_RESET;
        cmd_valid_r     <= 1'b0;
        ctx_idx_r       <= 5'h0;
        ctx_load_we_r   <= 1'b0;
        ctx_load_idx_r  <= 5'h0;
        ctx_load_data_r <= 32'h0;
        task_begin_r    <= 1'b0;
        handler_valid_r <= 1'b0;
        handler_sel_r   <= 16'h0;
        handler_off_r   <= 64'h0;
        handler_trap_r  <= 1'b0;
        stack_valid_r   <= 1'b0;
        stack_sel_r     <= 16'h0;
        stack_ptr_r     <= 64'h0;
        fault_r         <= 1'b0;
        fault_code_r    <= `TSID_FLT_NONE;
        tr_sel_r        <= 16'h0;
        tr_base_r       <= 64'h0;
        tr_limit_r      <= 20'h0;
    end
    else
    begin
        cmd_valid_r     <= 1'b0;
        ctx_load_we_r   <= 1'b0;
        task_begin_r    <= 1'b0;
        handler_valid_r <= 1'b0;
        stack_valid_r   <= 1'b0;
        fault_r         <= 1'b0;
        if (idt_wr)
        begin
            idt_base_r  <= idt_wbase;
            idt_limit_r <= idt_wlimit;
        end
        if (prio_wr && long_mode)
            tpl_r <= prio_wdata;
        // Issue the state's next access once the last one is answered
        if (state_r != ST_IDLE && state_r != ST_GATE &&
            state_r != ST_TRSET && !pend_r && cmd_ready &&
            !(state_r == ST_VEC && ent_last > idt_limit_r))
        begin
            cmd_valid_r <= 1'b1;
            pend_r      <= 1'b1;
        end
        case (state_r)
            ST_IDLE:
            begin
                cnt_r     <= 3'h0;
                pend_r    <= 1'b0;
                ld_only_r <= 1'b0;
                if (take_hw | take_ext | take_sw)
                begin
                    vec_r   <= take_hw ? hw_vec :
                               (take_ext ? ext_vec : sw_vec_sel);
                    state_r <= ST_VEC;
                end
                else if (take_tsw && long_mode)
                begin
                    fault_r      <= 1'b1;
                    fault_code_r <= `TSID_FLT_HW_SWITCH;
                end
                else if (take_tsw)
                begin
                    new_sel_r <= switch_sel;
                    ctx_idx_r <= `TSID_IDX_SAVE_FIRST;
                    state_r   <= ST_SAVE;
                end
                else if (take_trl)
                begin
                    new_sel_r <= tr_load_sel;
                    ld_only_r <= 1'b1;
                    state_r   <= ST_GDESC;
                end
            end
            ST_VEC:
            begin
                if (!pend_r && ent_last > idt_limit_r)
                begin
                    fault_r      <= 1'b1;
                    fault_code_r <= `TSID_FLT_LIMIT;
                    state_r      <= ST_IDLE;
                end
                else if (rsp_valid)
                begin
                    pend_r <= 1'b0;
                    cnt_r  <= last_wd ? 3'h0 : cnt_r + 3'h1;
                    if (last_wd)
                        state_r <= ST_GATE;
                end
            end
            ST_GATE:
            begin
                if (gate_typ == `TSID_TYPE_TASK && long_mode)
                begin
                    fault_r      <= 1'b1;
                    fault_code_r <= `TSID_FLT_TASK_GATE;
                    state_r      <= ST_IDLE;
                end
                else if (gate_typ == `TSID_TYPE_TASK)
                begin
                    new_sel_r <= desc_r[0][31:16];
                    ctx_idx_r <= `TSID_IDX_SAVE_FIRST;
                    state_r   <= ST_SAVE;
                end
                else if (is_int)
                begin
                    handler_sel_r  <= desc_r[0][31:16];
                    handler_off_r  <= {long_mode ? desc_r[2] : 32'h0,
                                       desc_r[1][31:16], desc_r[0][15:0]};
                    handler_trap_r <= gate_typ[0];
                    if (long_mode && gate_ist != 3'h0)
                    begin
                        stk_off_r <= `TSID_OFF_IST1 + {2'b0, ist_m1, 3'h0};
                        state_r   <= ST_STK;
                    end
                    else if (tgt_lvl < cpl)
                    begin
                        stk_off_r <= long_mode ?
                            (`TSID_OFF_RSP0 + {3'b0, tgt_lvl, 3'h0}) :
                            {1'b0, `TSID_IDX_PTR0 + {2'b0, tgt_lvl, 1'b0},
                             2'b00};
                        state_r   <= ST_STK;
                    end
                    else
                    begin
                        handler_valid_r <= 1'b1;
                        state_r         <= ST_IDLE;
                    end
                end
                else
                begin
                    fault_r      <= 1'b1;
                    fault_code_r <= `TSID_FLT_BAD_TYPE;
                    state_r      <= ST_IDLE;
                end
            end
            ST_STK:
            begin
                if (rsp_valid)
                begin
                    pend_r <= 1'b0;
                    cnt_r  <= cnt_r + 3'h1;
                    if (cnt_r == 3'h0)
                        stack_ptr_r <= {32'h0, rsp_data};
                    else
                    begin
                        if (long_mode)
                        begin
                            stack_ptr_r[63:32] <= rsp_data;
                            stack_sel_r        <= 16'h0;
                        end
                        else
                            stack_sel_r <= rsp_data[15:0];
                        stack_valid_r   <= 1'b1;
                        handler_valid_r <= 1'b1;
                        state_r         <= ST_IDLE;
                    end
                end
            end
            ST_SAVE:
            begin
                if (rsp_valid)
                begin
                    pend_r <= 1'b0;
                    if (ctx_idx_r == `TSID_IDX_SAVE_LAST)
                    begin
                        tr_sel_r <= new_sel_r;
                        cnt_r    <= 3'h0;
                        state_r  <= ST_GDESC;
                    end
                    else
                        ctx_idx_r <= ctx_idx_r + 5'h1;
                end
            end
            ST_GDESC:
            begin
                if (rsp_valid)
                begin
                    pend_r <= 1'b0;
                    cnt_r  <= last_wd ? 3'h0 : cnt_r + 3'h1;
                    if (last_wd)
                        state_r <= ST_TRSET;
                end
            end
            ST_TRSET:
            begin
                tr_base_r  <= {long_mode ? desc_r[2] : 32'h0,
                               desc_r[1][31:24], desc_r[1][7:0],
                               desc_r[0][31:16]};
                tr_limit_r <= {desc_r[1][19:16], desc_r[0][15:0]};
                if (ld_only_r)
                begin
                    tr_sel_r <= new_sel_r;
                    state_r  <= ST_IDLE;
                end
                else
                begin
                    ctx_idx_r <= `TSID_IDX_LOAD_FIRST;
                    state_r   <= ST_LOAD;
                end
            end
            default:
            begin
                if (rsp_valid)
                begin
                    pend_r          <= 1'b0;
                    ctx_load_we_r   <= 1'b1;
                    ctx_load_idx_r  <= ctx_idx_r;
                    ctx_load_data_r <= rsp_data;
                    ctx_idx_r       <= ctx_idx_r + 5'h1;
                    if (ctx_idx_r == `TSID_IDX_LOAD_LAST)
                    begin
                        task_begin_r <= 1'b1;
                        state_r      <= ST_IDLE;
                    end
                end
            end
        endcase
    end
end

// ----------------------------------------------------------------------
// Memory request port
// ----------------------------------------------------------------------
tsid_mem_port u_port
(
    .clk       (clk),
    .resetn    (resetn),
    .cmd_valid (cmd_valid_r),
    .cmd_we    (state_r == ST_SAVE),
    .cmd_addr  (acc_addr),
    .cmd_wdata (ctx_save_data),
    .cmd_ready (cmd_ready),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
);

endmodule

/* sim/tsid_assertions.sv */
// Port checker for the dispatch block
`timescale 1ns/1ns
module tsid_assertions
(
    // Clock, reset and mode
    input wire        clk,
    input wire        resetn,
    input wire        long_mode,
    // Requests and priority
    input wire        busy,
    input wire        hw_vec_ready,
    input wire        switch_ready,
    input wire [7:0]  ext_vec,
    input wire        ext_vec_ready,
    input wire        prio_wr,
    input wire [3:0]  prio_wdata,
    input wire [3:0]  prio_rdata,
    // Results
    input wire        task_begin_r,
    input wire        ctx_load_we_r,
    input wire [4:0]  ctx_load_idx_r,
    input wire        handler_valid_r,
    input wire        stack_valid_r,
    input wire [15:0] stack_sel_r,
    input wire [63:0] tr_base_r,
    input wire [63:0] iomap_word_addr,
    // Memory port
    input wire        mem_req,
    input wire        mem_ack,
    input wire [63:0] mem_addr
);
default clocking cb @(posedge clk); endclocking
default disable iff (!resetn);
// ----------------------------------------------------------------------
// Properties
// ----------------------------------------------------------------------
mem_hold_a: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr)) else $error("memory request dropped");
busy_refuse_a: assert property (busy |-> !hw_vec_ready
    && !switch_ready) else $error("request accepted while busy");
prio_class_a: assert property (ext_vec_ready |->
    ext_vec[7:4] > prio_rdata) else $error("low class accepted");
prio_write_a: assert property (prio_wr && long_mode |=>
    prio_rdata == $past(prio_wdata)) else $error("priority not written");
prio_keep_a: assert property (prio_wr && !long_mode |=>
    $stable(prio_rdata)) else $error("priority written outside long mode");
iomap_off_a: assert property (iomap_word_addr ==
    tr_base_r + 64'h64) else $error("bitmap offset wrong");
null_stack_a: assert property (stack_valid_r && long_mode |->
    stack_sel_r == 16'h0000) else $error("stack selector not null");
begin_last_a: assert property (task_begin_r |-> ctx_load_we_r
    && ctx_load_idx_r == 5'h18) else $error("task began early");
entry_pulse_a: assert property (handler_valid_r |=>
    !handler_valid_r) else $error("entry pulse too long");
c_entry: cover property (handler_valid_r);
c_stack: cover property (stack_valid_r);
c_begin: cover property (task_begin_r);
endmodule
bind tsid_dispatch tsid_assertions tsid_assertions_inst (.*);

/* sim/tsid_mem_model.sv */
// System memory model holding tables and records
`timescale 1ns/1ns
module tsid_mem_model
(
    // Clock and reset
    input wire        clk,
    input wire        resetn,
    // Request side
    input wire        mem_req,
    input wire        mem_we,
    input wire [63:0] mem_addr,
    input wire [31:0] mem_wdata,
    input wire [3:0]  lat,
    // Answer side
    output reg        mem_ack,
    output reg [31:0] mem_rdata,
    output reg [7:0]  wr_count
);
reg     [31:0] m [0:255];
reg     [3:0]  cnt_r;
integer        i;
// Clear the array so empty entries read as type zero
initial
begin
    for (i = 0; i < 256; i = i + 1)
        m[i] = 32'h0;
end
// One request at a time, answered after lat waits
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
        {mem_ack, cnt_r, wr_count, mem_rdata} <= 45'h0;
    else if (mem_req && !mem_ack && cnt_r == lat)
    begin
        mem_ack <= 1'b1;
        cnt_r <= 4'h0;
        mem_rdata <= m[mem_addr[9:2]];
        if (mem_we)
        begin
            m[mem_addr[9:2]] <= mem_wdata;
            wr_count <= wr_count + 8'h01;
        end
    end
    else
    begin
        mem_ack <= 1'b0;
        cnt_r <= (mem_req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
        mem_rdata <= ~mem_rdata; // No stale data between answers
    end
end
endmodule

/* sim/tb_top.sv */
// Testbench for the dispatch block
`timescale 1ns/1ns
module tb_top;
reg         clk, resetn, long_mode, idt_wr, prio_wr;
reg  [4:0]  vld;
reg  [15:0] dat, idt_wlimit;
reg  [1:0]  cpl;
reg  [63:0] gdt_base, idt_wbase;
reg  [3:0]  prio_wdata, lat;
wire        ctx_load_we_r, task_begin_r, handler_valid_r, handler_trap_r;
wire        stack_valid_r, fault_r, busy, mem_req, mem_we, mem_ack;
wire        ext_vec_ready;
wire [3:0]  prio_rdata;
wire [2:0]  fault_code_r;
wire [4:0]  ctx_idx_r, ctx_load_idx_r;
wire [7:0]  wr_count;
wire [15:0] handler_sel_r, stack_sel_r, tr_sel_r;
wire [19:0] tr_limit_r;
wire [31:0] ctx_load_data_r, mem_wdata, mem_rdata, ctx_save_data;
wire [63:0] handler_off_r, stack_ptr_r, tr_base_r, mem_addr, iomap_word_addr;
integer     bad_count = 0, check_count = 0, lc = 0, l0;
reg  [7:0]  w0, e;
assign ctx_save_data = {24'hA50000, 3'h0, ctx_idx_r};
tsid_dispatch tsid_dispatch_inst (.*, .hw_vec_valid(vld[0]),
    .hw_vec(dat[7:0]), .hw_vec_ready(), .ext_vec_valid(vld[1]),
    .ext_vec(dat[7:0]), .sw_vec_valid(vld[2]), .sw_kind(dat[9:8]),
    .sw_vec(dat[7:0]), .sw_vec_ready(), .switch_valid(vld[3]),
    .switch_sel(dat), .switch_ready(), .tr_load_valid(vld[4]),
    .tr_load_sel(dat), .tr_load_ready());
tsid_mem_model tsid_mem_model_inst (.*);
// Clock and load counter
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
always @(posedge clk) lc <= ctx_load_we_r ? lc + 1 : lc;
task chk(input [63:0] s, input [63:0] x);
begin
    check_count = check_count + 1;
    if (s !== x)
    begin
        $display("ERROR %0t got %h expected %h", $time, s, x);
        bad_count = bad_count + 1;
    end
end
endtask
task pre(input [7:0] a, input [31:0] d);
    tsid_mem_model_inst.m[a] = d;
endtask
// Pulse one request, then wait for idle
task fire(input [2:0] k, input [15:0] v);
    integer n;
begin
    @(posedge clk);
    vld <= 5'h01 << k;
    dat <= v;
    @(posedge clk);
    vld <= 5'h00;
    @(negedge clk);
    for (n = 0; n < 500 && busy !== 1'b0; n = n + 1) @(negedge clk);
    chk(n < 500, 1'b1);
end
endtask
task wr(input p, input [63:0] d);
begin
    @(posedge clk);
    {idt_wr, prio_wr} <= {~p, p};
    {idt_wbase, prio_wdata, idt_wlimit} <= {d, d[3:0], ~d[15:0]};
    @(posedge clk);
    {idt_wr, prio_wr} <= 2'h0;
    @(negedge clk);
end
endtask
task legacy_vectors;
    integer i;
begin
    pre(6, 32'h00100003); pre(7, 32'h0F00); pre(8, 32'h00100004);
    pre(9, 32'hE00); pre(10, 32'h00100005); pre(11, 32'hE00);
    pre(32, 32'h00100010); pre(33, 32'hE00);
    wr(0, 64'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
        e = (i == 0) ? 8'h10 : (i == 1) ? 8'h04 : (i == 2) ? 8'h03 : 8'h05;
        fire(2, {6'h0, i[1:0], 8'h10});
        chk(handler_off_r, e);
        chk(handler_trap_r, e == 8'h03);
    end
    fire(0, 16'h10);
    chk(handler_sel_r, 16'h0010);
    fire(1, 16'h90);
    chk(handler_off_r, 64'h10);
    fire(2, 16'h11);
    chk(fault_code_r, 3'h1);
end
endtask
task task_switch;
begin
    pre(132, 32'h03800067); pre(130, 32'h03000067); pre(216, 32'hABCD);
    lat <= 4'h2;
    fire(4, 16'h10);
    chk(tr_base_r, 64'h380);
    {l0, w0} = {lc, wr_count};
    fire(3, 16'h08);
    chk(task_begin_r, 1'b1);
    chk({tr_sel_r, tr_base_r}, {16'h8, 64'h300});
    chk({tr_limit_r, ctx_load_data_r}, {20'h67, 32'hABCD});
    @(negedge clk);
    chk(lc - l0, 18);
    chk(wr_count - w0, 16);
    chk(tsid_mem_model_inst.m[232], 32'hA5000008);
end
endtask
task long_checks;
begin
    wr(1, 64'h7);
    chk(prio_rdata, 4'h0);
    @(posedge clk) long_mode <= 1'b1;
    wr(1, 64'h5);
    chk(prio_rdata, 4'h5);
    fire(1, 16'h50);
    chk({ext_vec_ready, busy}, 2'h0);
    pre(68, 32'h00100001); pre(69, 32'hE00); pre(70, 32'h9);
    pre(193, 32'h1234); pre(194, 32'h1); pre(73, 32'h500);
    @(posedge clk) cpl <= 2'h3;
    wr(0, 64'h100);
    fire(2, 16'h01);
    chk(handler_off_r, 64'h9_0000_0001);
    chk({stack_valid_r, stack_sel_r}, 17'h10000);
    chk(stack_ptr_r, 64'h1_0000_1234);
    fire(2, 16'h02);
    chk(fault_code_r, 3'h2);
    fire(3, 16'h08);
    chk(fault_code_r, 3'h3);
    wr(0, 64'hFFF0);
    fire(2, 16'h01);
    chk(fault_code_r, 3'h4);
end
endtask
task tally_and_finish;
begin
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
end
endtask
// Main sequence
initial
begin
    {vld, dat, cpl, long_mode, idt_wr, idt_wbase, prio_wr} = 0;
    {prio_wdata, lat, resetn, idt_wlimit} = 0;
    gdt_base = 64'h200;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    legacy_vectors;
    task_switch;
    long_checks;
    tally_and_finish;
end
// Watchdog
initial
begin
    #200000;
    bad_count = bad_count + 1;
    tally_and_finish;
end
endmodule
